// ### design/vwac_pkg.sv
// Shared constants for the variable-width adder and clip datapath.
package vwac_pkg;
	// Parameter store layout.
	localparam int PRM_COUNT = 23;
	localparam logic [4:0] ADDR_SHIFT_A = 5'h0d;
	localparam logic [4:0] ADDR_SHIFT_B = 5'h0e;
	localparam logic [4:0] ADDR_FORMAT = 5'h0f;
	localparam logic [4:0] ADDR_RND_CLIP = 5'h10;
	localparam logic [4:0] ADDR_QUIET = 5'h15;
	localparam logic [4:0] ADDR_WIDTH_MODE = 5'h16;
	localparam logic [4:0] ADDR_LAST = 5'h16;
	localparam logic [3:0] PRM_RST = 4'h0;
	// Field positions inside the parameter nibbles.
	localparam int BIT_FMT_A = 0;
	localparam int BIT_FMT_B = 1;
	localparam int BIT_TRUNC_A = 0;
	localparam int BIT_TRUNC_B = 1;
	localparam int BIT_CLIP_A = 2;
	localparam int BIT_CLIP_B = 3;
	localparam int BIT_QUIET_D = 2;
	localparam int BIT_QUIET_E = 3;
	localparam int BIT_WIDTH_EN = 0;
	// Datapath widths.
	localparam logic [4:0] W_NORMAL = 5'h10;
	localparam logic [4:0] W_WIDE = 5'h14;
	localparam logic [4:0] W_NARROW = 5'h0c;
	localparam logic [2:0] SHIFT_MAX = 3'h4;
	// Adder operation codes from the control pins.
	localparam logic [1:0] OP_ADD = 2'h0;
	localparam logic [1:0] OP_CONV = 2'h1;
	localparam logic [1:0] OP_FEED = 2'h2;
	localparam logic [1:0] OP_ZERO = 2'h3;
	// Counts of cycles.
	localparam logic [4:0] EXT_LOAD_EDGE = 5'h0f;
	localparam logic [4:0] EXT_CNT_STOP = 5'h10;
	localparam int RESET_MIN_CYCLES = 4;
	// Synchroniser reset value: select and strobes idle high, everything else low.
	localparam logic [12:0] SYNC_RST = 13'h0007;
endpackage

// ### design/vwac_lane.sv
// One adder lane: bus conversion, add, variable rounding shift and clip.
`timescale 1ns/100ps
module vwac_lane (
	input wire logic [15:0] conv_i,
	input wire logic [19:0] feed_i,
	input wire logic [4:0] feed_w_i,
	input wire logic [4:0] width_i,
	input wire logic signed_i,
	input wire logic [1:0] op_i,
	input wire logic [2:0] shift_i,
	input wire logic trunc_i,
	input wire logic clip_i,
	output logic [19:0] res_o
);
	// Extend the low w bits of x to 24 bits, by sign or by zero.
	function automatic logic signed [23:0] vwac_ext(input logic [19:0] x, input logic [4:0] w,
		input logic sgn);
		logic [23:0] m;
		logic [23:0] v;
		m = (24'h1 << w) - 24'h1;
		v = {4'h0, x} & m;
		if (sgn && x[w - 5'h1]) begin
			v = v | ~m;
		end
		return signed'(v);
	endfunction

	// Upper or lower limit of a w-bit range.
	function automatic logic signed [23:0] vwac_bound(input logic [4:0] w, input logic sgn,
		input logic hi);
		logic signed [23:0] one;
		one = 24'sh1;
		if (sgn) begin
			return hi ? (one <<< (w - 5'h1)) - one : -(one <<< (w - 5'h1));
		end
		return hi ? (one <<< w) - one : 24'sh0;
	endfunction

	localparam logic [4:0] W_CONV = vwac_pkg::W_NORMAL;

	logic signed [23:0] a_s;
	logic signed [23:0] b_s;
	logic signed [23:0] sum_s;
	logic signed [23:0] sat_s;
	logic signed [23:0] rnd_s;
	logic signed [23:0] sh_s;
	logic signed [23:0] cl_s;
	logic [4:0] lim_w;
	logic ovf_hi;

	// Conversion output is always 16 bits; both operands join at bit zero.
	always_comb begin
		a_s = vwac_ext({4'h0, conv_i}, W_CONV, signed_i);
		b_s = vwac_ext(feed_i, feed_w_i, signed_i);
		unique case (op_i)
			vwac_pkg::OP_ADD: sum_s = a_s + b_s;
			vwac_pkg::OP_CONV: sum_s = a_s;
			vwac_pkg::OP_FEED: sum_s = b_s;
			vwac_pkg::OP_ZERO: sum_s = 24'sh0;
		endcase
		// An add that leaves the lane width saturates before the shift.
		sat_s = sum_s;
		ovf_hi = 1'b0;
		if (sum_s > vwac_bound(width_i, signed_i, 1'b1)) begin
			sat_s = vwac_bound(width_i, signed_i, 1'b1);
			ovf_hi = 1'b1;
		end else if (sum_s < vwac_bound(width_i, signed_i, 1'b0)) begin
			sat_s = vwac_bound(width_i, signed_i, 1'b0);
		end
		// Rounding adds one at bit n, counting the LSB as one.
		rnd_s = (shift_i != 3'h0 && !trunc_i) ? (24'sh1 <<< 3'(shift_i - 3'h1)) : 24'sh0;
		sh_s = (sat_s + rnd_s) >>> shift_i;
		// Clip against what still fits the lane width once shifted back.
		lim_w = width_i - {2'h0, shift_i};
		cl_s = sh_s;
		if (clip_i && sh_s > vwac_bound(lim_w, signed_i, 1'b1)) begin
			cl_s = vwac_bound(lim_w, signed_i, 1'b1);
		end else if (clip_i && sh_s < vwac_bound(lim_w, signed_i, 1'b0)) begin
			cl_s = vwac_bound(lim_w, signed_i, 1'b0);
		end
		// An add overflow must end at the top of the range; without this, rounding would lift it past clip-off.
		if (ovf_hi) begin
			cl_s = vwac_bound(lim_w, signed_i, 1'b1);
		end
		res_o = cl_s[19:0];
	end
endmodule

// ### design/vwac_buf.sv
// Two-entry skid buffer with registered outputs.
`timescale 1ns/100ps
module vwac_buf #(
	parameter int WIDTH = 32
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	logic out_valid_q, out_valid_d, skid_valid_q, skid_valid_d;
	logic in_ready_q, in_ready_d;
	logic [WIDTH-1:0] out_data_q, out_data_d, skid_q, skid_d;

	// The second entry catches the word accepted in the stall cycle, so ready can be registered.
	always_comb begin
		out_valid_d = out_valid_q;
		out_data_d = out_data_q;
		skid_valid_d = skid_valid_q;
		skid_d = skid_q;
		if (out_ready_i || !out_valid_q) begin
			if (skid_valid_q) begin
				out_data_d = skid_q;
				out_valid_d = 1'b1;
				skid_valid_d = 1'b0;
			end else begin
				out_valid_d = in_valid_i;
				out_data_d = in_valid_i ? in_data_i : out_data_q;
			end
		end else if (in_valid_i && !skid_valid_q) begin
			skid_d = in_data_i;
			skid_valid_d = 1'b1;
		end
		// Ready is kept in its own flop so the port comes straight from a register.
		in_ready_d = !skid_valid_d;
	end

	// Register stage.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			out_valid_q <= 1'b0;
			skid_valid_q <= 1'b0;
			in_ready_q <= 1'b1;
			out_data_q <= '0;
			skid_q <= '0;
		end else begin
			out_valid_q <= out_valid_d;
			skid_valid_q <= skid_valid_d;
			in_ready_q <= in_ready_d;
			out_data_q <= out_data_d;
			skid_q <= skid_d;
		end
	end

	assign in_ready_o = in_ready_q;
	assign out_valid_o = out_valid_q;
	assign out_data_o = out_data_q;
endmodule

// ### design/vwac_top.sv
// Variable-width adder and clip output datapath with its parameter store.
`timescale 1ns/100ps
// Overview of operation
// - Conversion inputs always 16 bits, same both modes.
// - Normal mode: both adders work at 16 bits.
// - Width mode: adder A works at 20 bits.
// - Width mode: adder B clipped to 12 bits.
// - Shift, round, clip follow each adder width.
// - Operands join the adders at bit zero.
// - Width mismatch extended by sign or zero.
// - Quiet masks act on wide and narrow inputs.
// - Overflow detection at 20 and 12 bits.
// - Unsigned clip to largest value, else pass overflow.
// - Addition overflow before shift saturates at the limit it passed, top or bottom.
// - Signed: top bit is sign, overflow there.
// - Rounding adds one at bit n.
// - Bus conversion ahead of each adder.
// - Write captured when select or store rises.
// - Read data driven only while both low.
// - External load samples data at 16th edge.
// - Width mode maps wide ports across A and B.
// - Width mode enabled by address 16 bit 0.
// - Format bit: zero signed, one unsigned.
module vwac_top (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic cs_n_i,
	input wire logic store_n_i,
	input wire logic fetch_n_i,
	input wire logic [4:0] addr_i,
	input wire logic [3:0] wdata_i,
	output logic [3:0] rdata_o,
	output logic rdata_oe_o,
	input wire logic external_param_load_mode_i,
	input wire logic [91:0] ext_param_data_i,
	input wire logic [15:0] conv_a_i,
	input wire logic [15:0] conv_b_i,
	input wire logic [15:0] input_port_d_i,
	input wire logic [15:0] input_port_e_i,
	input wire logic [1:0] adder_a_ctl_i,
	input wire logic [1:0] adder_b_ctl_i,
	input wire logic shift_en_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [15:0] output_port_a_o,
	output logic [15:0] output_port_b_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and glitch filter.

	logic [12:0] pins;
	logic [12:0] s1_q, s2_q, s3_q, filt_q, filt_d;

	assign pins = {external_param_load_mode_i, wdata_i, addr_i, fetch_n_i, store_n_i, cs_n_i};

	// A bit of the filter only moves once the second and third stages agree.
	always_comb begin
		for (int i = 0; i < 13; i++) begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		end
	end

	// Three synchroniser flops and a filter flop per pin; the first stage feeds only the second.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s1_q <= vwac_pkg::SYNC_RST;
			s2_q <= vwac_pkg::SYNC_RST;
			s3_q <= vwac_pkg::SYNC_RST;
			filt_q <= vwac_pkg::SYNC_RST;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	logic cs_n_f, store_n_f, fetch_n_f, ext_mode_f;
	logic [4:0] addr_f;
	logic [3:0] wdata_f;
	assign {ext_mode_f, wdata_f, addr_f, fetch_n_f, store_n_f, cs_n_f} = filt_q;

	////////////////////////////////////////////////////////////////////////////////
	// Parameter store, host strobes and external load.

	logic [3:0] prm_q [vwac_pkg::PRM_COUNT];
	logic [3:0] prm_d [vwac_pkg::PRM_COUNT];
	logic wr_act, rd_act, wr_act_q, wr_act_d, ext_load;
	logic [4:0] addr_h_q, addr_h_d, cnt_q, cnt_d;
	logic [3:0] data_h_q, data_h_d, rdata_q, rdata_d;
	logic rdata_oe_q, rdata_oe_d;

	assign wr_act = !cs_n_f && !store_n_f;
	assign rd_act = !cs_n_f && !fetch_n_f;
	assign ext_load = ext_mode_f && (cnt_q == vwac_pkg::EXT_LOAD_EDGE);

	// Address and data follow the pins while the write is open, are held once it closes, and are committed when either strobe rises.
	// An external load in the same cycle overrides a host write.
	always_comb begin
		wr_act_d = wr_act;
		addr_h_d = wr_act ? addr_f : addr_h_q;
		data_h_d = wr_act ? wdata_f : data_h_q;
		cnt_d = (cnt_q == vwac_pkg::EXT_CNT_STOP) ? cnt_q : cnt_q + 5'h1;
		for (int i = 0; i < vwac_pkg::PRM_COUNT; i++) begin
			prm_d[i] = prm_q[i];
		end
		if (wr_act_q && !wr_act && addr_h_q <= vwac_pkg::ADDR_LAST) begin
			prm_d[addr_h_q] = data_h_q;
		end
		if (ext_load) begin
			for (int i = 0; i < vwac_pkg::PRM_COUNT; i++) begin
				prm_d[i] = ext_param_data_i[4*i +: 4];
			end
		end
		// Read data is driven only while both strobes are low; unmapped reads give zero.
		rdata_oe_d = rd_act;
		rdata_d = (rd_act && addr_f <= vwac_pkg::ADDR_LAST) ? prm_q[addr_f] : 4'h0;
	end

	// Every parameter is zero after reset.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			for (int i = 0; i < vwac_pkg::PRM_COUNT; i++) begin
				prm_q[i] <= vwac_pkg::PRM_RST;
			end
			wr_act_q <= 1'b0;
			addr_h_q <= 5'h00;
			data_h_q <= 4'h0;
			cnt_q <= 5'h00;
			rdata_q <= 4'h0;
			rdata_oe_q <= 1'b0;
		end else begin
			for (int i = 0; i < vwac_pkg::PRM_COUNT; i++) begin
				prm_q[i] <= prm_d[i];
			end
			wr_act_q <= wr_act_d;
			addr_h_q <= addr_h_d;
			data_h_q <= data_h_d;
			cnt_q <= cnt_d;
			rdata_q <= rdata_d;
			rdata_oe_q <= rdata_oe_d;
		end
	end

	assign rdata_o = rdata_q;
	assign rdata_oe_o = rdata_oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Parameter decode.

	logic width_mode_enable, signed_a, signed_b;
	logic [2:0] shift_a, shift_b;
	logic [4:0] width_a, width_b, feed_w_a, feed_w_b;

	// Shift codes five to seven are outside the legal range and are held at four; bit 3 of the code is ignored.
	function automatic logic [2:0] vwac_shift(input logic [3:0] code, input logic en);
		logic [2:0] s;
		s = code[2:0];
		if (s > vwac_pkg::SHIFT_MAX) begin
			s = vwac_pkg::SHIFT_MAX;
		end
		return en ? s : 3'h0;
	endfunction

	assign width_mode_enable = prm_q[vwac_pkg::ADDR_WIDTH_MODE][vwac_pkg::BIT_WIDTH_EN];
	assign signed_a = !prm_q[vwac_pkg::ADDR_FORMAT][vwac_pkg::BIT_FMT_A];
	assign signed_b = !prm_q[vwac_pkg::ADDR_FORMAT][vwac_pkg::BIT_FMT_B];
	assign shift_a = vwac_shift(prm_q[vwac_pkg::ADDR_SHIFT_A], shift_en_i);
	assign shift_b = vwac_shift(prm_q[vwac_pkg::ADDR_SHIFT_B], shift_en_i);
	// Lane widths set overflow detection, feed extension and clip points.
	assign width_a = width_mode_enable ? vwac_pkg::W_WIDE : vwac_pkg::W_NORMAL;
	assign width_b = width_mode_enable ? vwac_pkg::W_NARROW : vwac_pkg::W_NORMAL;
	assign feed_w_a = width_a;
	assign feed_w_b = width_b;

	////////////////////////////////////////////////////////////////////////////////
	// Input port mapping and quiet masks.

	logic [19:0] wide_input_d, feed_a, feed_b;
	logic [11:0] narrow_input_e;
	logic [15:0] port_d_m, port_e_m;
	logic quiet_mask_port_d, quiet_mask_port_e;

	assign quiet_mask_port_d = prm_q[vwac_pkg::ADDR_QUIET][vwac_pkg::BIT_QUIET_D];
	assign quiet_mask_port_e = prm_q[vwac_pkg::ADDR_QUIET][vwac_pkg::BIT_QUIET_E];

	// In width mode the masks follow the wide and narrow ports, not the pins.
	always_comb begin
		port_d_m = quiet_mask_port_d ? 16'h0000 : input_port_d_i;
		port_e_m = quiet_mask_port_e ? 16'h0000 : input_port_e_i;
		wide_input_d = {input_port_e_i[15:12], input_port_d_i};
		narrow_input_e = input_port_e_i[11:0];
		if (quiet_mask_port_d) begin
			wide_input_d = 20'h00000;
		end
		if (quiet_mask_port_e) begin
			narrow_input_e = 12'h000;
		end
		feed_a = width_mode_enable ? wide_input_d : {4'h0, port_d_m};
		feed_b = width_mode_enable ? {8'h00, narrow_input_e} : {4'h0, port_e_m};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Adder lanes.

	logic [19:0] wide_output_a, narrow_output_b;

	vwac_lane u_lane_a (
		.conv_i(conv_a_i),
		.feed_i(feed_a),
		.feed_w_i(feed_w_a),
		.width_i(width_a),
		.signed_i(signed_a),
		.op_i(adder_a_ctl_i),
		.shift_i(shift_a),
		.trunc_i(prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_TRUNC_A]),
		.clip_i(prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_A]),
		.res_o(wide_output_a)
	);

	vwac_lane u_lane_b (
		.conv_i(conv_b_i),
		.feed_i(feed_b),
		.feed_w_i(feed_w_b),
		.width_i(width_b),
		.signed_i(signed_b),
		.op_i(adder_b_ctl_i),
		.shift_i(shift_b),
		.trunc_i(prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_TRUNC_B]),
		.clip_i(prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_B]),
		.res_o(narrow_output_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Output port mapping and skid buffer.

	logic [31:0] out_word, buf_word;

	// The top four bits of the wide result borrow the upper nibble of port B.
	assign out_word = width_mode_enable ?
		{wide_output_a[15:0], wide_output_a[19:16], narrow_output_b[11:0]} :
		{wide_output_a[15:0], narrow_output_b[15:0]};

	vwac_buf #(.WIDTH(32)) u_buf (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o),
		.in_data_i(out_word),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(buf_word)
	);

	assign output_port_a_o = buf_word[31:16];
	assign output_port_b_o = buf_word[15:0];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	AST_WRITE_COMMIT: assert property (
		wr_act_q && !wr_act && !ext_load && addr_h_q <= vwac_pkg::ADDR_LAST
		|=> prm_q[$past(addr_h_q)] == $past(data_h_q))
		else $error("parameter write not committed at strobe release");

	AST_READ_WINDOW: assert property (
		rd_act
		|=> rdata_oe_o && rdata_o == $past((addr_f <= vwac_pkg::ADDR_LAST) ? prm_q[addr_f] : 4'h0))
		else $error("read enable or data does not follow strobes");

	AST_READ_RELEASE: assert property (
		!rd_act |=> !rdata_oe_o && rdata_o == 4'h0)
		else $error("read bus not released");

	AST_EXT_LOAD: assert property (
		ext_load |=> prm_q[vwac_pkg::ADDR_WIDTH_MODE] == $past(ext_param_data_i[91:88]))
		else $error("external parameter load missed");

	AST_LANE_WIDTH: assert property (
		width_mode_enable |-> width_a == vwac_pkg::W_WIDE && width_b == vwac_pkg::W_NARROW)
		else $error("lane widths wrong in width mode");

	AST_NARROW_CLIP: assert property (
		width_mode_enable && !signed_b && prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_B]
		|-> narrow_output_b[19:12] == 8'h00)
		else $error("narrow result exceeds 12 bits");

	AST_WIDE_UNS_CLIP: assert property (
		!signed_a && prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_A]
		|-> {1'b0, wide_output_a} < (21'h1 << (width_a - {2'h0, shift_a})))
		else $error("wide unsigned result above clip limit");

	// Signed clipping keeps every bit above the shifted-back sign position equal to the sign.
	AST_WIDE_SGN_CLIP: assert property (
		signed_a && prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_A]
		|-> ($signed(wide_output_a) >>> (width_a - {2'h0, shift_a} - 5'h1)) inside {20'hfffff, 20'h00000})
		else $error("wide signed result outside clip range");

	AST_NARROW_SGN_CLIP: assert property (
		signed_b && prm_q[vwac_pkg::ADDR_RND_CLIP][vwac_pkg::BIT_CLIP_B]
		|-> ($signed(narrow_output_b) >>> (width_b - {2'h0, shift_b} - 5'h1)) inside {20'hfffff, 20'h00000})
		else $error("narrow signed result outside clip range");

	AST_EXT_ONCE: assert property (
		cnt_q == vwac_pkg::EXT_CNT_STOP |=> cnt_q == vwac_pkg::EXT_CNT_STOP)
		else $error("load counter moved after its stop");

	AST_QUIET_WIDE: assert property (
		width_mode_enable && quiet_mask_port_d |-> feed_a == 20'h00000)
		else $error("quiet mask did not clear wide input");

	AST_SHIFT_RANGE: assert property (
		shift_a <= vwac_pkg::SHIFT_MAX && shift_b <= vwac_pkg::SHIFT_MAX)
		else $error("shift beyond four");

	AST_ZERO_OP: assert property (
		adder_a_ctl_i == vwac_pkg::OP_ZERO |-> wide_output_a == 20'h00000)
		else $error("zero operation gave nonzero");

	AST_OUT_HOLD: assert property (
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(output_port_a_o) && $stable(output_port_b_o))
		else $error("output changed while stalled");

	COV_WIDTH_WRITE: cover property (wr_act_q && !wr_act && addr_h_q == vwac_pkg::ADDR_WIDTH_MODE);
	COV_EXT_LOAD: cover property (ext_load);
	COV_STALL_FULL: cover property (out_valid_o && !out_ready_i && !in_ready_o);
	COV_WIDE_CLIP: cover property (width_mode_enable && shift_a == vwac_pkg::SHIFT_MAX && in_valid_i);
	COV_ADD_OVF: cover property (adder_a_ctl_i == vwac_pkg::OP_ADD && u_lane_a.ovf_hi && in_valid_i);
endmodule

// ### dv/vwac_partner.sv
// Host parameter bus and downstream sink model for the adder and clip datapath.
`timescale 1ns/100ps
module vwac_partner (
	input wire logic clock_i,
	input wire logic [1:0] sink_mode_i,
	input wire logic [3:0] rdata_i,
	input wire logic rdata_oe_i,
	output logic cs_n_o,
	output logic store_n_o,
	output logic fetch_n_o,
	output logic [4:0] addr_o,
	output logic [3:0] wdata_o,
	output logic out_ready_o
);
	logic [2:0] cnt = 3'h0;

	// Idle bus: both strobes and the select are parked high.
	initial begin
		cs_n_o = 1'b1;
		store_n_o = 1'b1;
		fetch_n_o = 1'b1;
		addr_o = 5'h00;
		wdata_o = 4'h0;
		out_ready_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// Write: hold select and store low together, then raise both at once.
	// The long hold covers the pin filter, so no write is lost to it.
	task automatic wr(input logic [4:0] a, input logic [3:0] d);
		@(negedge clock_i);
		addr_o = a;
		wdata_o = d;
		cs_n_o = 1'b0;
		store_n_o = 1'b0;
		repeat (6) @(negedge clock_i);
		cs_n_o = 1'b1;
		store_n_o = 1'b1;
		repeat (6) @(negedge clock_i);
	endtask

	// Read: data is taken while select and fetch are both still low.
	task automatic rd(input logic [4:0] a, output logic [3:0] d, output logic oe);
		@(negedge clock_i);
		addr_o = a;
		cs_n_o = 1'b0;
		fetch_n_o = 1'b0;
		repeat (7) @(negedge clock_i);
		d = rdata_i;
		oe = rdata_oe_i;
		cs_n_o = 1'b1;
		fetch_n_o = 1'b1;
		repeat (7) @(negedge clock_i);
	endtask

	////////////////////////////////////////////////////////////////
	// Sink: always ready, never ready, or a stuttering pattern that stalls often.
	always @(negedge clock_i) begin
		cnt <= cnt + 3'h1;
		out_ready_o <= (sink_mode_i == 2'h0) || (sink_mode_i == 2'h2 && (cnt[0] ^ cnt[2]));
	end
endmodule

// ### dv/tb_vwac_top.sv
// Self-checking testbench for the variable-width adder and clip datapath.
`timescale 1ns/100ps
module tb_vwac_top;
	logic clock_i, srst_i, external_param_load_mode_i, shift_en_i, in_valid_i, run, took, wm, oe;
	logic [91:0] ext_param_data_i;
	logic [15:0] conv_a_i, conv_b_i, input_port_d_i, input_port_e_i, output_port_a_o, output_port_b_o;
	logic [1:0] adder_a_ctl_i, adder_b_ctl_i, sink;
	logic [3:0] fmt, rc, q, d, rdata_o;
	logic [2:0] sha, shb;
	logic [31:0] r, r2, r3, seed = 32'h60;
	logic [23:0] pv;
	logic rdata_oe_o, in_ready_o, out_valid_o;
	wire cs_n_i, store_n_i, fetch_n_i, out_ready_i;
	wire [4:0] addr_i;
	wire [3:0] wdata_i;
	int mismatches = 0, samples_checked = 0, nacc = 0, cn = 4, k;
	logic [31:0] exp_q[$];
	logic [23:0] phases[6] = '{24'h00c021, 24'h13c043, 24'h130040, 24'h10c042, 24'h103c14, 24'h031430};
	logic [4:0] addrs[6];
	logic [47:0] corner[4] = '{48'h0000ffff_f000, 48'h80008000_f000, 48'h0001ffff_7000, 48'h7fff8000_7000};

	vwac_top u_vwac_top (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .store_n_i(store_n_i),
		.fetch_n_i(fetch_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o),
		.external_param_load_mode_i(external_param_load_mode_i), .ext_param_data_i(ext_param_data_i),
		.conv_a_i(conv_a_i), .conv_b_i(conv_b_i), .input_port_d_i(input_port_d_i),
		.input_port_e_i(input_port_e_i), .adder_a_ctl_i(adder_a_ctl_i), .adder_b_ctl_i(adder_b_ctl_i),
		.shift_en_i(shift_en_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
		.output_port_a_o(output_port_a_o), .output_port_b_o(output_port_b_o), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i));

	vwac_partner u_vwac_partner (.clock_i(clock_i), .sink_mode_i(sink), .rdata_i(rdata_o),
		.rdata_oe_i(rdata_oe_o), .cs_n_o(cs_n_i), .store_n_o(store_n_i), .fetch_n_o(fetch_n_i),
		.addr_o(addr_i), .wdata_o(wdata_i), .out_ready_o(out_ready_i));

	////////////////////////////////////////////////////////////////
	// Clock at 250 MHz.
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// Repeatable xorshift source.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// One lane: extend, add, saturate on add overflow, round at bit n, shift, clip to width minus shift.
	// Wide arithmetic keeps the rounding carry that a narrow model would drop.
	function automatic logic [19:0] lane(input logic [15:0] c, input logic [19:0] f, input int w, input logic sg,
		input logic [1:0] op, input int n, input logic tr, input logic cl);
		longint a, b, s, lo, hi, v;
		a = sg ? longint'($signed(c)) : longint'(c);
		b = longint'(f);
		if (sg && f[w-1]) b = b - (longint'(1) << w);
		hi = sg ? (longint'(1) << (w - 1)) - 1 : (longint'(1) << w) - 1;
		lo = sg ? -(longint'(1) << (w - 1)) : 0;
		s = (op[1] ? 0 : a) + (op[0] ? 0 : b);
		if (s > hi) return 20'(hi >>> n);
		if (s < lo) return 20'(lo >>> n);
		v = (n > 0 && !tr) ? (s + (longint'(1) << (n - 1))) >>> n : s >>> n;
		if (cl && v > (hi >>> n)) v = hi >>> n;
		if (cl && v < (lo >>> n)) v = lo >>> n;
		return 20'(v);
	endfunction

	// Expected port pair for the word now on the inputs.
	function automatic logic [31:0] expect_out();
		logic [19:0] fd, fe, ra, rb;
		int na, nb;
		na = shift_en_i ? ((sha > 3'h4) ? 4 : int'(sha)) : 0;
		nb = shift_en_i ? ((shb > 3'h4) ? 4 : int'(shb)) : 0;
		if (wm) begin
			fd = q[2] ? 20'h0 : {input_port_e_i[15:12], input_port_d_i};
			fe = q[3] ? 20'h0 : {8'h0, input_port_e_i[11:0]};
			ra = lane(conv_a_i, fd, 20, !fmt[0], adder_a_ctl_i, na, rc[0], rc[2]);
			rb = lane(conv_b_i, fe, 12, !fmt[1], adder_b_ctl_i, nb, rc[1], rc[3]);
			return {ra[15:0], ra[19:16], rb[11:0]};
		end
		fd = q[2] ? 20'h0 : {4'h0, input_port_d_i};
		fe = q[3] ? 20'h0 : {4'h0, input_port_e_i};
		ra = lane(conv_a_i, fd, 16, !fmt[0], adder_a_ctl_i, na, rc[0], rc[2]);
		rb = lane(conv_b_i, fe, 16, !fmt[1], adder_b_ctl_i, nb, rc[1], rc[3]);
		return {ra[15:0], rb[15:0]};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Bounded wait until every accepted word has left the buffer.
	task automatic wait_drain();
		k = 0;
		while ((exp_q.size() != 0 || out_valid_o !== 1'b0 || in_valid_i !== 1'b0) && k < 300) begin
			@(negedge clock_i);
			k++;
		end
		check("drain", 32'(k < 300), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////
	// Stimulus at the falling edge; a word is held until it is taken. Corner words lead each phase.
	always @(negedge clock_i) begin
		r = rnd();
		r2 = rnd();
		r3 = rnd();
		if (!run && (!in_valid_i || took)) begin
			in_valid_i <= 1'b0;
		end else if (!in_valid_i || took) begin
			conv_b_i <= wm ? (fmt[1] ? {3'h0, r[28:16]} : {{3{r[28]}}, r[28:16]}) : r[31:16];
			adder_b_ctl_i <= r3[3:2];
			if (cn < 4) begin
				{conv_a_i, input_port_d_i, input_port_e_i} <= corner[cn];
				adder_a_ctl_i <= 2'h0;
				shift_en_i <= 1'b1;
				in_valid_i <= 1'b1;
				cn <= cn + 1;
			end else begin
				conv_a_i <= r[15:0];
				{input_port_e_i, input_port_d_i} <= r2;
				adder_a_ctl_i <= r3[1:0];
				shift_en_i <= r3[4] | r3[5];
				in_valid_i <= r3[6] | r3[7];
			end
		end
	end

	// Scoreboard: predict on acceptance, compare on delivery, so a stalled word must survive.
	always @(posedge clock_i) begin
		took <= in_valid_i && in_ready_o && !srst_i;
		if (!srst_i && out_valid_o === 1'b1 && out_ready_i) begin
			if (exp_q.size() == 0) check("extra", 32'h1, 32'h0);
			else check("ports", {output_port_a_o, output_port_b_o}, exp_q.pop_front());
		end
		if (!srst_i && in_valid_i && in_ready_o === 1'b1) begin
			exp_q.push_back(expect_out());
			nacc++;
		end
	end

	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////
	// Main sequence: reset, per-phase parameter set with read-back, streaming, fill test, external load.
	initial begin
		addrs = '{vwac_pkg::ADDR_WIDTH_MODE, vwac_pkg::ADDR_FORMAT, vwac_pkg::ADDR_RND_CLIP, vwac_pkg::ADDR_QUIET,
			vwac_pkg::ADDR_SHIFT_A, vwac_pkg::ADDR_SHIFT_B};
		{external_param_load_mode_i, shift_en_i, in_valid_i, run, took, wm} = '0;
		{ext_param_data_i, conv_a_i, conv_b_i, input_port_d_i, input_port_e_i} = '0;
		{adder_a_ctl_i, adder_b_ctl_i, sink, fmt, rc, q, sha, shb} = '0;
		srst_i = 1'b1;
		repeat (6) @(negedge clock_i);
		srst_i = 1'b0;
		check("ready", 32'(in_ready_o), 32'h1);
		check("valid", 32'(out_valid_o), 32'h0);
		u_vwac_partner.rd(vwac_pkg::ADDR_SHIFT_A, d, oe);
		check("param_rst", {28'h0, d}, 32'h0);
		for (int p = 0; p < 6; p++) begin
			pv = phases[p];
			for (int i = 0; i < 6; i++) begin
				u_vwac_partner.wr(addrs[i], pv[23-4*i -: 4]);
				u_vwac_partner.rd(addrs[i], d, oe);
				check("readback", {27'h0, oe, d}, {27'h1, pv[23-4*i -: 4]});
				check("release", 32'(rdata_oe_o), 32'h0);
			end
			u_vwac_partner.rd(5'h17, d, oe);
			check("unmapped", {28'h0, d}, 32'h0);
			{wm, fmt, rc, q, sha, shb} = {pv[20], pv[19:8], pv[6:4], pv[2:0]};
			sink = p[0] ? 2'h2 : 2'h0;
			cn = 0;
			k = nacc + 40;
			run = 1'b1;
			while (nacc < k && k < 100000) @(negedge clock_i);
			run = 1'b0;
			wait_drain();
		end
		// Stalled sink: the buffer must fill and refuse, then give back every word.
		sink = 2'h1;
		run = 1'b1;
		repeat (16) @(negedge clock_i);
		check("full", {30'h0, in_ready_o, out_valid_o}, 32'h1);
		run = 1'b0;
		sink = 2'h0;
		wait_drain();
		// External load: parameters come from the data pins at the sixteenth edge after reset.
		external_param_load_mode_i = 1'b1;
		for (int i = 0; i < 23; i++) ext_param_data_i[4*i +: 4] = 4'(i * 3 + 1);
		srst_i = 1'b1;
		repeat (6) @(negedge clock_i);
		srst_i = 1'b0;
		repeat (24) @(negedge clock_i);
		u_vwac_partner.rd(vwac_pkg::ADDR_SHIFT_B, d, oe);
		check("ext_load", {28'h0, d}, 32'hb);
		u_vwac_partner.rd(vwac_pkg::ADDR_WIDTH_MODE, d, oe);
		check("ext_load", {28'h0, d}, 32'h3);
		tally_and_finish();
	end
endmodule
